//--- hdl/adc_capture_pkg.sv
// Constants shared by the converter capture block and its test bench
package adc_capture_pkg;
	// Clocking
	localparam int unsigned CLOCK_PERIOD_NS = 50;
	localparam int unsigned SOURCE_CLOCK_HZ = 9216000;
	localparam int unsigned CONV_CLOCK_HZ = 1152000;
	localparam int unsigned CONV_DIVIDE = SOURCE_CLOCK_HZ / CONV_CLOCK_HZ;
	localparam logic [2:0] CONV_HALF_LAST = 3'((CONV_DIVIDE / 2) - 1);

	// Serial capture
	localparam int unsigned RESULT_BITS = 16;
	localparam int unsigned COUNT_BITS = 4;
	localparam logic [3:0] TERMINAL_COUNT = 4'hf;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic [15:0] SHIFT_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam int unsigned FIFO_DEPTH = 4;

	// Analog input select register fields
	localparam int unsigned SELECT_BITS = 4;
	localparam int unsigned SELECT_ENABLE_BIT = 3;
	localparam int unsigned SELECT_INDEX_MSB = 2;
	localparam logic [3:0] SELECT_RESET = 4'h0;

	// Positions in the synchronised pin vector
	localparam int unsigned SYNC_W = 14;
	localparam int unsigned PIN_DATA_LSB = 0;
	localparam int unsigned PIN_SELECT_N = 8;
	localparam int unsigned PIN_START_N = 9;
	localparam int unsigned PIN_READ_N = 10;
	localparam int unsigned PIN_SDATA = 11;
	localparam int unsigned PIN_SCLK = 12;
	localparam int unsigned PIN_CHANNEL = 13;
	localparam logic [13:0] SYNC_RESET = 14'h3fff;
endpackage : adc_capture_pkg

//--- hdl/adc_serial_capture.sv
// Serial result capture, result latch and analog input select for the converter
//
// Summary of operation
// R01: Select one of eight analog inputs
// R02: Processor writes select byte with strobe
// R03: Bit 3 enables, bits 2..0 pick input
// R04: Upper four select bits are ignored
// R05: Converter shifts result with its own clock
// R06: Shift clock alone advances counter, shifter, flag
// R07: Each shift clock shifts bit, bumps counter
// R08: Terminal flag high after fifteen bits
// R09: Sixteenth shift clock completes the capture
// R10: Completion raises interrupt and loads latches
// R11: Read strobe resets counter, clears interrupt
// R12: Start strobe clears the shift register
// R13: Processor starts conversion via chip select
// R14: Converter clock is source divided by eight; the code divides this block's own clock by eight
// R15: Latched bit picks converter channel
// R16: Latches hold result until next transfer
`timescale 1ns/1ns
module adc_serial_capture
	import adc_capture_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	input wire logic [7:0] i_quiet_data,
	input wire logic i_analog_select_strobe_n,
	input wire logic i_conv_start_n,
	input wire logic i_result_read_n,
	input wire logic i_serial_clock,
	input wire logic i_serial_data,
	input wire logic i_channel_pick,
	output logic o_mux_enable,
	output logic [2:0] o_mux_index,
	output logic o_converter_channel_pick,
	output logic o_converter_clock,
	output logic o_counter_terminal_flag,
	output logic o_conversion_done_irq,
	output logic [15:0] o_result,
	output logic o_capture_ready
);
	// Pin synchronisers
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] prev_q;

	assign pin_raw = {i_channel_pick, i_serial_clock, i_serial_data, i_result_read_n,
		i_conv_start_n, i_analog_select_strobe_n, i_quiet_data};

	// Data pins pass the same two stages so the byte lines up with its strobe
	for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				sync1_q[g] <= SYNC_RESET[g];
				sync2_q[g] <= SYNC_RESET[g];
				prev_q[g] <= SYNC_RESET[g];
			end else if (i_clk_en) begin
				sync1_q[g] <= pin_raw[g];
				sync2_q[g] <= sync1_q[g];
				prev_q[g] <= sync2_q[g];
			end
		end
	end

	// Rising edge of a synchronised pin: second stage high, delayed copy still low
	function automatic logic rose_edge(input logic now_lvl, input logic was_lvl);
		return now_lvl & ~was_lvl;
	endfunction : rose_edge

	logic sclk_rise;
	logic select_write;
	logic read_low;
	logic start_low;
	assign sclk_rise = rose_edge(sync2_q[PIN_SCLK], prev_q[PIN_SCLK]); // [R05] [R06]
	// Data is taken at the trailing edge of the strobe, one stage back, so it is the byte held while low
	assign select_write = rose_edge(sync2_q[PIN_SELECT_N], prev_q[PIN_SELECT_N]);
	assign read_low = ~sync2_q[PIN_READ_N];
	assign start_low = ~sync2_q[PIN_START_N];

	// Analog input select register
	logic [SELECT_BITS-1:0] select_q, select_d;
	logic channel_q, channel_d;

	always_comb begin
		select_d = select_q;
		if (select_write) begin
			select_d = prev_q[PIN_DATA_LSB +: SELECT_BITS]; // [R02] [R03] [R04]
		end
		channel_d = sync2_q[PIN_CHANNEL]; // [R15]
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			select_q <= SELECT_RESET;
			channel_q <= 1'b1;
		end else if (i_clk_en) begin
			select_q <= select_d;
			channel_q <= channel_d;
		end
	end

	assign o_mux_enable = select_q[SELECT_ENABLE_BIT]; // [R01] [R03]
	assign o_mux_index = select_q[SELECT_INDEX_MSB:0]; // [R01] [R03]
	assign o_converter_channel_pick = channel_q;

	// Converter clock divider
	// Runs from this block's own clock rather than a separate source clock
	logic [2:0] div_q, div_d;
	logic conv_clk_q, conv_clk_d;

	always_comb begin
		div_d = 3'(div_q + 1'b1);
		conv_clk_d = conv_clk_q;
		if (div_q == CONV_HALF_LAST) begin
			div_d = 3'h0;
			conv_clk_d = ~conv_clk_q; // [R14]
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= 3'h0;
			conv_clk_q <= 1'b0;
		end else if (i_clk_en) begin
			div_q <= div_d;
			conv_clk_q <= conv_clk_d;
		end
	end

	assign o_converter_clock = conv_clk_q;

	// Serial capture: shifter, bit counter, terminal flag
	logic [RESULT_BITS-1:0] shift_q, shift_d;
	logic [COUNT_BITS-1:0] count_q, count_d;
	logic term_q, term_d;
	logic [RESULT_BITS-1:0] word_in;
	logic push;
	logic fifo_ready;

	always_comb begin
		word_in = {shift_q[RESULT_BITS-2:0], sync2_q[PIN_SDATA]};
		shift_d = shift_q;
		count_d = count_q;
		push = 1'b0;
		if (sclk_rise) begin
			shift_d = word_in; // [R07]
			count_d = COUNT_BITS'(count_q + 1'b1); // [R07]
			push = term_q & ~read_low; // [R09]
		end
		// A held start clears the shifter and beats a coincident shift clock
		if (start_low) begin
			shift_d = SHIFT_RESET; // [R12]
		end
		if (read_low) begin
			count_d = COUNT_RESET; // [R11]
		end
		term_d = (count_d == TERMINAL_COUNT); // [R08]
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			shift_q <= SHIFT_RESET;
			count_q <= COUNT_RESET;
			term_q <= 1'b0;
		end else if (i_clk_en) begin
			shift_q <= shift_d;
			count_q <= count_d;
			term_q <= term_d;
		end
	end

	assign o_counter_terminal_flag = term_q;

	// Completed words queue here; a word pushed while the queue is full is lost
	logic fifo_valid;
	logic [RESULT_BITS-1:0] fifo_data;
	logic pop;

	result_fifo #(
		.WIDTH(RESULT_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_result_fifo (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_clk_en(i_clk_en),
		.i_in_valid(push),
		.i_in_data(word_in),
		.o_in_ready(fifo_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(pop)
	);

	assign o_capture_ready = fifo_ready;

	// Result latch and completion flag
	logic done_q, done_d;
	logic [RESULT_BITS-1:0] result_q, result_d;

	always_comb begin
		// The latch drains the queue only once software has taken the previous word
		// A long read strobe drains one queued word per cycle, so keep reads short
		pop = fifo_valid & (~done_q | read_low);
		done_d = done_q;
		result_d = result_q;
		if (read_low) begin
			done_d = 1'b0; // [R11]
		end
		// Set beats clear so a word arriving during the read is not missed
		if (pop) begin
			done_d = 1'b1; // [R10]
			result_d = fifo_data; // [R10] [R16]
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			done_q <= 1'b0;
			result_q <= RESULT_RESET;
		end else if (i_clk_en) begin
			done_q <= done_d;
			result_q <= result_d;
		end
	end

	assign o_conversion_done_irq = done_q;
	assign o_result = result_q;

	// Checks
	default clocking cb @(posedge i_clock iff i_clk_en);
	endclocking
	default disable iff (!i_nrst);

	a_select_write: assert property (select_write |=> select_q == $past(prev_q[3:0])) // [R03]
		else $error("select register did not take the low nibble");
	a_select_hold: assert property (!select_write |=> $stable(select_q)) // [R04]
		else $error("select register changed without a strobe");
	a_count_step: assert property (sclk_rise && !read_low |=> count_q == 4'($past(count_q) + 1'b1)) // [R07]
		else $error("bit counter did not advance on shift clock");
	a_count_idle: assert property (!sclk_rise && !read_low |=> $stable(count_q)) // [R06]
		else $error("capture state moved without a shift clock");
	a_terminal_flag: assert property (term_q |-> count_q == TERMINAL_COUNT) // [R08]
		else $error("terminal flag not tied to fifteen bits");
	a_push_at_end: assert property (push |-> term_q && sclk_rise) // [R09]
		else $error("capture completed before the sixteenth bit");
	a_done_load: assert property (pop |=> done_q && result_q == $past(fifo_data)) // [R10]
		else $error("completion did not load latch and raise interrupt");
	a_end_to_irq: assert property (push && fifo_ready && !done_q && !fifo_valid |-> ##2 done_q) // [R10]
		else $error("interrupt late after completed capture");
	a_read_clear: assert property (read_low && !pop |=> !done_q && count_q == COUNT_RESET) // [R11]
		else $error("read strobe did not clear counter and interrupt");
	a_start_clear: assert property (start_low |=> shift_q == SHIFT_RESET) // [R12]
		else $error("start strobe did not clear shifter");
	a_latch_hold: assert property (!pop |=> $stable(result_q)) // [R16]
		else $error("result latch changed without a transfer");
	a_conv_clock: assert property ($rose(conv_clk_q) |-> ##4 $fell(conv_clk_q)) // [R14]
		else $error("converter clock half period wrong");
	a_channel_follow: assert property (##1 channel_q == $past(sync2_q[PIN_CHANNEL])) // [R15]
		else $error("channel pick not following its input");

	// Serial framing: shifter, bit counter, terminal flag and word completion
	a_shift_idle: assert property (!sclk_rise && !start_low |=> $stable(shift_q)) // [R06]
		else $error("shifter moved without a shift clock");
	a_shift_in: assert property (sclk_rise && !start_low |=> shift_q == $past(word_in)) // [R07]
		else $error("serial bit not shifted in");
	a_term_rise: assert property ($rose(term_q) |-> $past(sclk_rise)) // [R08]
		else $error("terminal flag rose without a shift clock");
	a_push_at_term: assert property (sclk_rise && term_q && !read_low |-> push) // [R09]
		else $error("sixteenth bit did not complete the word");
	a_count_wrap: assert property (sclk_rise && term_q && !read_low |=> count_q == COUNT_RESET && !term_q) // [R09]
		else $error("bit counter did not wrap after sixteen bits");
	a_read_no_push: assert property (read_low |-> !push) // [R11]
		else $error("word completed while the read strobe was low");
	a_term_clear_read: assert property (read_low |=> !term_q) // [R11]
		else $error("read strobe did not clear the terminal flag");

	// Interrupt, latch and queue
	a_irq_hold: assert property (done_q && !read_low |=> done_q) // [R10]
		else $error("interrupt dropped without a read");
	a_irq_rise_load: assert property ($rose(done_q) |-> $past(pop)) // [R10]
		else $error("interrupt rose without a latch load");
	a_irq_fall_read: assert property ($fell(done_q) |-> $past(read_low)) // [R11]
		else $error("interrupt cleared without a read");
	a_drain_prompt: assert property (fifo_valid && !done_q |-> pop) // [R10]
		else $error("queued word not moved to the latch");
	a_full_drop: assert property (!fifo_ready && !pop |=> !fifo_ready) // [R16]
		else $error("full queue took a word");

	// Divider and clock enable
	a_div_toggle: assert property ($changed(conv_clk_q) |-> $past(div_q) == CONV_HALF_LAST) // [R14]
		else $error("converter clock toggled off count");
	a_enable_freeze: assert property (@(posedge i_clock) disable iff (!i_nrst) !i_clk_en |=> // [R06]
		$stable(result_q) && $stable(select_q) && $stable(count_q) && $stable(done_q))
		else $error("state moved while the clock enable was low");

	c_capture_done: cover property (push ##[1:3] done_q);
	c_queue_drain: cover property (pop && read_low);
	c_read_clear: cover property (done_q ##1 read_low ##1 !done_q);
	c_select_write: cover property (select_write ##1 o_mux_enable);
	c_fifo_full: cover property (!fifo_ready);
endmodule : adc_serial_capture

//--- hdl/result_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and registered flags
`timescale 1ns/1ns
module result_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 4
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] count_q, count_d;
	logic ready_q, ready_d, valid_q, valid_d;
	logic push, pop;

	always_comb begin
		push = i_in_valid & ready_q;
		pop = valid_q & i_out_ready;
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		count_d = count_q;
		if (push) begin
			mem_d[wr_q] = i_in_data;
			wr_d = (wr_q == LAST_C) ? '0 : AW'(wr_q + 1'b1);
		end
		if (pop) begin
			rd_d = (rd_q == LAST_C) ? '0 : AW'(rd_q + 1'b1);
		end
		if (push && !pop) begin
			count_d = (AW + 1)'(count_q + 1'b1);
		end else if (pop && !push) begin
			count_d = (AW + 1)'(count_q - 1'b1);
		end
		// Flags are registered so the ports come straight from flip-flops
		ready_d = (count_d != DEPTH_C);
		valid_d = (count_d != '0);
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			ready_q <= 1'b1;
			valid_q <= 1'b0;
		end else if (i_clk_en) begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			count_q <= count_d;
			ready_q <= ready_d;
			valid_q <= valid_d;
		end
	end

	assign o_in_ready = ready_q;
	assign o_out_valid = valid_q;
	assign o_out_data = mem_q[rd_q];
endmodule : result_fifo

//--- test/adc_serial_capture_test.sv
// Self-checking bench for the converter capture block
`timescale 1ns/1ns
module adc_serial_capture_test;
	import adc_capture_pkg::*;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] data = 8'h00;
	logic sel_n = 1'b1, start_n = 1'b1, read_n = 1'b1, chan = 1'b1;
	logic en = 1'b1;
	logic sclk, sdata, mux_en, conv_clk, term, irq, ready, ch_out;
	logic [2:0] mux_idx;
	logic [15:0] result, res_prev = 16'h0000, last_w = 16'h0000;
	logic irq_prev = 1'b0;
	logic [15:0] exp_q[$];
	int n_errors = 0;
	int checked = 0;

	always #25 i_clock = ~i_clock;

	adc_serial_capture adc_serial_capture_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(en),
		.i_quiet_data(data), .i_analog_select_strobe_n(sel_n), .i_conv_start_n(start_n),
		.i_result_read_n(read_n), .i_serial_clock(sclk), .i_serial_data(sdata), .i_channel_pick(chan),
		.o_mux_enable(mux_en), .o_mux_index(mux_idx), .o_converter_channel_pick(ch_out),
		.o_converter_clock(conv_clk), .o_counter_terminal_flag(term), .o_conversion_done_irq(irq),
		.o_result(result), .o_capture_ready(ready));

	converter_model converter_model_inst (.i_clock(i_clock), .o_sclk(sclk), .o_sdata(sdata));

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic conclude();
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask : step

	task automatic write_sel(input logic [7:0] b);
		data = b;
		sel_n = 1'b0;
		step(4);
		sel_n = 1'b1;
		step(6);
		cmp({12'h000, mux_en, mux_idx}, {12'h000, b[3:0]});
	endtask : write_sel

	// A fresh word always differs from the one before, so the watcher sees every load
	task automatic word(input int half, input bit kept);
		logic [15:0] w;
		w = 16'($urandom);
		if (w === last_w) w = ~w;
		last_w = w;
		if (kept) exp_q.push_back(w);
		converter_model_inst.send(w, 15, 0, half);
		step(6);
	endtask : word

	task automatic read(input int n);
		read_n = 1'b0;
		step(n);
		read_n = 1'b1;
		step(4);
	endtask : read

	// Every new word in the result latch is matched against the oldest note
	always @(negedge i_clock) begin
		if (irq === 1'b1 && (irq_prev !== 1'b1 || result !== res_prev)) begin
			if (exp_q.size() == 0) begin
				cmp(result, ~result);
			end else begin
				cmp(result, exp_q.pop_front());
			end
		end
		irq_prev <= irq;
		res_prev <= result;
	end

	initial begin
		#(CLOCK_PERIOD_NS * 20000);
		n_errors++;
		conclude();
	end

	initial begin
		logic [15:0] w;
		void'($urandom(57));
		step(2);
		i_nrst = 1'b1;
		step(3);
		for (int i = 0; i < 8; i++) begin
			write_sel({4'($urandom), i[0], i[2:0]});
		end
		// Clock enable low freezes the pins as well, so this strobe is never seen
		en = 1'b0;
		data = 8'h00;
		sel_n = 1'b0;
		step(4);
		sel_n = 1'b1;
		step(6);
		en = 1'b1;
		step(6);
		cmp({12'h000, mux_en, mux_idx}, 16'h000f);
		for (int i = 0; i < 2; i++) begin
			chan = i[0];
			step(4);
			cmp({15'h0000, ch_out}, {15'h0000, chan});
		end
		w[0] = conv_clk;
		for (int k = 1; k < 4; k++) begin
			step(4);
			cmp({15'h0000, conv_clk}, {15'h0000, w[0] ^ k[0]});
		end
		// Fifteen bits raise the terminal flag, the sixteenth completes the word
		w = 16'($urandom);
		last_w = w;
		exp_q.push_back(w);
		converter_model_inst.send(w, 15, 1, 3);
		step(6);
		cmp({15'h0000, term}, 16'h0001);
		converter_model_inst.send(w, 0, 0, 3);
		step(6);
		cmp({15'h0000, term}, 16'h0000);
		read(4);
		cmp({15'h0000, irq}, 16'h0000);
		// Aborted frame: read resets the count, start clears the shifter
		converter_model_inst.send(16'($urandom), 15, 9, 3);
		read(4);
		start_n = 1'b0;
		step(4);
		start_n = 1'b1;
		step(4);
		cmp({15'h0000, irq}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			word(3 + 3 * i[0], 1'b1);
			read(4);
		end
		// Fill the latch and the buffer with no reads; the sixth word is dropped
		for (int i = 0; i < 6; i++) begin
			word(3, i < 5);
		end
		cmp({15'h0000, ready}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			read(4);
		end
		cmp({15'h0000, irq}, 16'h0000);
		cmp({15'h0000, ready}, 16'h0001);
		cmp(16'(exp_q.size()), 16'h0000);
		conclude();
	end
endmodule : adc_serial_capture_test

//--- test/converter_model.sv
// Behavioural converter that shifts its result out on its own clock
`timescale 1ns/1ns
module converter_model (
	input wire logic i_clock,
	output logic o_sclk,
	output logic o_sdata
);
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
	end

	// Sends bits hi down to lo, first bit is w[hi]; clock rests low between frames
	task automatic send(input logic [15:0] w, input int hi, input int lo, input int half);
		for (int i = hi; i >= lo; i--) begin
			o_sdata = w[i];
			repeat (half) @(posedge i_clock);
			#2 o_sclk = 1'b1;
			repeat (half) @(posedge i_clock);
			#2 o_sclk = 1'b0;
		end
		// Released line shows the inverse so a stale bit cannot look right
		o_sdata = ~o_sdata;
	endtask : send
endmodule : converter_model
